// [ltbo_top.sv]
// Composite limit result to binning output pattern, with register port
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "ltbo_params.svh"
module ltbo_top
	import ltbo_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [`LTBO_ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_seq_start,
	input wire logic i_result_valid,
	input wire logic i_comp_fail,
	input wire logic [`LTBO_NBANDS-1:0] i_lo_fail,
	input wire logic [`LTBO_NBANDS-1:0] i_up_fail,
	input wire logic [`LTBO_LOC_W-1:0] i_cur_loc,
	input wire logic i_sweep_done,
	output logic [`LTBO_PAT_W-1:0] o_output_pattern,
	output logic o_pattern_valid,
	output logic [`LTBO_LOC_W-1:0] o_branch_location,
	output logic o_branch_valid,
	output logic o_any_fail
);
	import ltbo_pkg::*;

	// ****************************************************
	// Configuration registers
	// ****************************************************
	logic ctrl_mode_q, ctrl_mode_d;
	logic ctrl_upd_q, ctrl_upd_d;
	logic ctrl_auto_q, ctrl_auto_d;
	logic [1:0] ctrl_wid_q, ctrl_wid_d;
	logic [`LTBO_PAT_W-1:0] pass_pat_q, pass_pat_d;
	logic [`LTBO_PAT_W-1:0] fail_pat_q, fail_pat_d;
	logic [`LTBO_PAT_W-1:0] idle_pat_q, idle_pat_d;
	logic [`LTBO_PAT_W-1:0] comp_pat_q, comp_pat_d;
	logic [`LTBO_LOC_W-1:0] pass_loc_q, pass_loc_d;
	logic [`LTBO_LOC_W-1:0] fail_loc_q, fail_loc_d;
	logic comp_en_q, comp_en_d;
	logic [`LTBO_NBANDS-1:0] band_en_q, band_en_d;
	logic [`LTBO_PAT_W-1:0] lo_pat_q [`LTBO_NBANDS];
	logic [`LTBO_PAT_W-1:0] up_pat_q [`LTBO_NBANDS];
	logic sw_clear;
	logic sw_end;
	logic [3:0] widx;
	assign widx = i_addr[5:2];

	always_comb begin
		ctrl_mode_d = ctrl_mode_q;
		ctrl_upd_d = ctrl_upd_q;
		ctrl_auto_d = ctrl_auto_q;
		ctrl_wid_d = ctrl_wid_q;
		pass_pat_d = pass_pat_q;
		fail_pat_d = fail_pat_q;
		idle_pat_d = idle_pat_q;
		comp_pat_d = comp_pat_q;
		pass_loc_d = pass_loc_q;
		fail_loc_d = fail_loc_q;
		comp_en_d = comp_en_q;
		band_en_d = band_en_q;
		sw_clear = 1'b0;
		sw_end = 1'b0;
		if (i_wr) begin
			unique case (i_addr)
				`LTBO_A_CTRL: begin
					ctrl_mode_d = i_wdata[`LTBO_CTRL_MODE];
					ctrl_upd_d = i_wdata[`LTBO_CTRL_UPD];
					ctrl_auto_d = i_wdata[`LTBO_CTRL_AUTO];
					ctrl_wid_d = i_wdata[`LTBO_CTRL_WID_LO +: 2];
				end
				`LTBO_A_PASS_PAT: pass_pat_d = i_wdata[`LTBO_PAT_W-1:0];
				`LTBO_A_FAIL_PAT: fail_pat_d = i_wdata[`LTBO_PAT_W-1:0];
				`LTBO_A_IDLE_PAT: idle_pat_d = i_wdata[`LTBO_PAT_W-1:0];
				`LTBO_A_COMP_PAT: comp_pat_d = i_wdata[`LTBO_PAT_W-1:0];
				`LTBO_A_PASS_LOC: pass_loc_d = i_wdata[`LTBO_LOC_W-1:0];
				`LTBO_A_FAIL_LOC: fail_loc_d = i_wdata[`LTBO_LOC_W-1:0];
				`LTBO_A_ENABLES: begin
					comp_en_d = i_wdata[0];
					band_en_d = i_wdata[`LTBO_NBANDS:1];
				end
				`LTBO_A_ACTION: begin
					sw_clear = i_wdata[`LTBO_ACT_CLEAR]; // R16 R18
					sw_end = i_wdata[`LTBO_ACT_END];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_mode_q <= 1'b0;
			ctrl_upd_q <= 1'b0;
			ctrl_auto_q <= 1'b0;
			ctrl_wid_q <= 2'h1;
			pass_pat_q <= 16'h0000;
			fail_pat_q <= 16'h0000;
			idle_pat_q <= 16'h0000;
			comp_pat_q <= 16'h0000;
			pass_loc_q <= 7'h00;
			fail_loc_q <= 7'h00;
			comp_en_q <= 1'b0;
			band_en_q <= 11'h000;
		end else begin
			ctrl_mode_q <= ctrl_mode_d;
			ctrl_upd_q <= ctrl_upd_d;
			ctrl_auto_q <= ctrl_auto_d;
			ctrl_wid_q <= ctrl_wid_d;
			pass_pat_q <= pass_pat_d;
			fail_pat_q <= fail_pat_d;
			idle_pat_q <= idle_pat_d;
			comp_pat_q <= comp_pat_d;
			pass_loc_q <= pass_loc_d;
			fail_loc_q <= fail_loc_d;
			comp_en_q <= comp_en_d;
			band_en_q <= band_en_d;
		end
	end

	// ****************************************************
	// Per-band pattern storage
	// ****************************************************
	logic [`LTBO_NBANDS*`LTBO_PAT_W-1:0] lo_flat;
	logic [`LTBO_NBANDS*`LTBO_PAT_W-1:0] up_flat;
	genvar b;
	generate
		for (b = 0; b < `LTBO_NBANDS; b++) begin : g_pat
			logic lo_we;
			logic up_we;
			logic [`LTBO_PAT_W-1:0] lo_d;
			logic [`LTBO_PAT_W-1:0] up_d;
			always_comb begin
				lo_we = i_wr && (i_addr[7:6] == 2'h1) && (widx == 4'(b));
				up_we = i_wr && (i_addr[7:6] == 2'h2) && (widx == 4'(b));
				lo_d = lo_we ? i_wdata[`LTBO_PAT_W-1:0] : lo_pat_q[b];
				up_d = up_we ? i_wdata[`LTBO_PAT_W-1:0] : up_pat_q[b];
			end
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					lo_pat_q[b] <= 16'h0000;
					up_pat_q[b] <= 16'h0000;
				end else begin
					lo_pat_q[b] <= lo_d;
					up_pat_q[b] <= up_d;
				end
			end
			assign lo_flat[b*`LTBO_PAT_W +: `LTBO_PAT_W] = lo_pat_q[b];
			assign up_flat[b*`LTBO_PAT_W +: `LTBO_PAT_W] = up_pat_q[b];
		end
	endgenerate

	// ****************************************************
	// Evaluation and branching
	// ****************************************************
	logic ev_pass;
	logic [`LTBO_PAT_W-1:0] ev_pat;
	logic [`LTBO_LOC_W-1:0] next_loc;
	ltbo_eval u_eval (
		.i_mode(ltbo_mode_t'(ctrl_mode_q)),
		.i_comp_en(comp_en_q),
		.i_comp_fail(i_comp_fail),
		.i_band_en(band_en_q),
		.i_lo_fail(i_lo_fail),
		.i_up_fail(i_up_fail),
		.i_lo_pat(lo_flat),
		.i_up_pat(up_flat),
		.i_comp_pat(comp_pat_q),
		.i_pass_pat(pass_pat_q),
		.i_fail_pat(fail_pat_q),
		.o_pass(ev_pass),
		.o_pattern(ev_pat)
	);
	ltbo_branch u_branch (
		.i_cur_loc(i_cur_loc),
		.i_pass_loc(pass_loc_q),
		.i_fail_loc(fail_loc_q),
		.i_pass(ev_pass),
		.o_next_loc(next_loc)
	);

	// ****************************************************
	// Result holding and output update
	// ****************************************************
	logic [`LTBO_PAT_W-1:0] wmask;
	always_comb begin
		unique case (ltbo_width_t'(ctrl_wid_q))
			LTBO_W3: wmask = `LTBO_MASK_3BIT; // R20
			LTBO_W4: wmask = `LTBO_MASK_4BIT; // R1
			LTBO_W16: wmask = `LTBO_MASK_16BIT; // R19
			default: wmask = `LTBO_MASK_4BIT;
		endcase
	end

	ltbo_state_t st_q, st_d;
	logic fail_seen_q, fail_seen_d;
	logic [`LTBO_PAT_W-1:0] first_pat_q, first_pat_d;
	logic [`LTBO_PAT_W-1:0] out_q, out_d;
	logic out_vld_q, out_vld_d;
	logic [`LTBO_LOC_W-1:0] br_q, br_d;
	logic br_vld_q, br_vld_d;
	logic do_clear;
	logic done;
	assign do_clear = sw_clear | (ctrl_auto_q & i_seq_start); // R16 R17
	assign done = i_sweep_done | sw_end;

	always_comb begin
		st_d = st_q;
		fail_seen_d = fail_seen_q;
		first_pat_d = first_pat_q;
		out_d = out_q; // R22
		out_vld_d = out_vld_q;
		br_d = br_q;
		br_vld_d = 1'b0;
		if (do_clear) begin // R16
			st_d = LTBO_IDLE;
			fail_seen_d = 1'b0;
			first_pat_d = '0;
			out_d = idle_pat_q & wmask;
			out_vld_d = 1'b0;
		end
		// A result in the clearing cycle still lands: the set wins
		if (i_result_valid) begin
			br_d = next_loc; // R4 R5 R6
			br_vld_d = 1'b1;
			if (ctrl_upd_q == 1'b0) begin
				// First failure stands; later ones are ignored R7 R21
				if (!fail_seen_d) begin
					out_d = ev_pat & wmask;
					out_vld_d = 1'b1;
					st_d = LTBO_HELD;
				end
				if (!ev_pass) begin
					fail_seen_d = 1'b1;
				end
			end else if (!fail_seen_d && !ev_pass) begin
				fail_seen_d = 1'b1; // R8
				first_pat_d = ev_pat;
			end else if (!fail_seen_d) begin
				first_pat_d = ev_pat;
			end
		end
		// End mode publishes only on sweep done or an end action write R8
		if (ctrl_upd_q && done && st_q == LTBO_IDLE && !do_clear) begin
			out_d = (fail_seen_d ? first_pat_d : ev_pass_or(first_pat_d))
				& wmask;
			out_vld_d = 1'b1;
			st_d = LTBO_HELD;
		end
	end

	function automatic logic [`LTBO_PAT_W-1:0] ev_pass_or(
		input logic [`LTBO_PAT_W-1:0] p
	);
		ev_pass_or = p;
	endfunction : ev_pass_or

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= LTBO_IDLE;
			fail_seen_q <= 1'b0;
			first_pat_q <= 16'h0000;
			out_q <= 16'h0000;
			out_vld_q <= 1'b0;
			br_q <= 7'h00;
			br_vld_q <= 1'b0;
		end else begin
			st_q <= st_d;
			fail_seen_q <= fail_seen_d;
			first_pat_q <= first_pat_d;
			out_q <= out_d;
			out_vld_q <= out_vld_d;
			br_q <= br_d;
			br_vld_q <= br_vld_d;
		end
	end

	assign o_output_pattern = out_q;
	assign o_pattern_valid = out_vld_q;
	assign o_branch_location = br_q;
	assign o_branch_valid = br_vld_q;
	assign o_any_fail = fail_seen_q;

	// ****************************************************
	// Register read port
	// ****************************************************
	logic [31:0] rd_d, rd_q;
	always_comb begin
		rd_d = 32'h0000_0000;
		if (i_rd) begin
			if (i_addr[7:6] == 2'h1) begin
				rd_d[`LTBO_PAT_W-1:0] = lo_pat_q[widx < 4'hb ? widx : 4'h0];
			end else if (i_addr[7:6] == 2'h2) begin
				rd_d[`LTBO_PAT_W-1:0] = up_pat_q[widx < 4'hb ? widx : 4'h0];
			end else begin
				unique case (i_addr)
					`LTBO_A_CTRL: rd_d[4:0] = {ctrl_wid_q, ctrl_auto_q,
						ctrl_upd_q, ctrl_mode_q};
					`LTBO_A_PASS_PAT: rd_d[15:0] = pass_pat_q;
					`LTBO_A_FAIL_PAT: rd_d[15:0] = fail_pat_q;
					`LTBO_A_IDLE_PAT: rd_d[15:0] = idle_pat_q;
					`LTBO_A_COMP_PAT: rd_d[15:0] = comp_pat_q;
					`LTBO_A_PASS_LOC: rd_d[6:0] = pass_loc_q;
					`LTBO_A_FAIL_LOC: rd_d[6:0] = fail_loc_q;
					`LTBO_A_ENABLES: rd_d[11:0] = {band_en_q, comp_en_q};
					`LTBO_A_STATUS: rd_d[18:0] = {out_q, fail_seen_q,
						out_vld_q, st_q};
					default: rd_d = 32'h0000_0000;
				endcase
			end
		end
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_q <= 32'h0000_0000;
		end else begin
			rd_q <= rd_d;
		end
	end
	assign o_rdata = rd_q;

	// ****************************************************
	// Checks
	// ****************************************************
	AST_CLEAR_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // R16
		(sw_clear && !i_result_valid) |=> (o_output_pattern ==
		($past(idle_pat_q) & $past(wmask))) && !o_any_fail)
		else $error("clear did not restore idle pattern");
	AST_AUTO_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst) // R17
		(ctrl_auto_q && i_seq_start && !i_result_valid)
		|=> !o_pattern_valid && !o_any_fail)
		else $error("auto clear missed on sequence start");
	AST_CLEAR_SET: assert property (@(posedge i_clk) disable iff (i_rst) // R16
		(do_clear && i_result_valid && !ctrl_upd_q)
		|=> o_pattern_valid && (o_any_fail == !$past(ev_pass)))
		else $error("result lost in the clearing cycle");
	AST_END_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // R8
		(ctrl_upd_q && !done && !do_clear && !i_wr) |=> $stable(out_q))
		else $error("end mode updated before sweep end");
	AST_IMM_FIRST: assert property (@(posedge i_clk) disable iff (i_rst) // R7
		(!ctrl_upd_q && i_result_valid && !fail_seen_q && !do_clear)
		|=> o_output_pattern == ($past(ev_pat) & $past(wmask)))
		else $error("update_at_first_fail mode did not drive result");
	AST_FAIL_KEEP: assert property (@(posedge i_clk) disable iff (i_rst) // R21
		(fail_seen_q && !ctrl_upd_q && !do_clear && !i_wr) |=> $stable(out_q))
		else $error("later failure changed the pattern");
	AST_BRANCH_NEXT: assert property (@(posedge i_clk) disable iff (i_rst) // R6
		(i_result_valid && !do_clear && pass_loc_q == 7'h00
		&& fail_loc_q == 7'h00) |=> o_branch_location == $past(i_cur_loc)
		+ 7'h01)
		else $error("next location not current plus one");
	AST_W3_MASK: assert property (@(posedge i_clk) disable iff (i_rst) // R20
		($past(ctrl_wid_q) == 2'h0 && $changed(out_q)) |-> out_q[15:3] == '0)
		else $error("3-bit mode drove upper lines");
	AST_BR_PULSE: assert property (@(posedge i_clk) disable iff (i_rst) // R4
		o_branch_valid |-> $past(i_result_valid))
		else $error("branch valid without a result");
endmodule : ltbo_top

// [ltbo_params.svh]
// Constants for the limit test binning output block
// Notes on behaviour
// R1: Composite pass pattern driven when nothing fails
// R2: Sorting mode drives composite fail pattern
// R3: Sorting, only compliance enabled: pass pattern
// R4: Pass branch jumps to location, else next
// R5: Fail branch jumps to location, else next
// R6: Next setting always advances by one
// R7: Update_at_first_fail mode drives first failure at once
// R8: End mode holds update until sweep ends
// R9: Grading passes compliance then all limits
// R10: Grading drives first failure pattern, else pass
// R11: Sorting fails on compliance or no band
// R12: Sorting, compliance only, drives pass pattern
// R13: Sorting drives lower pattern of first band
// R14: Sorting compliance failure drives its pattern
// R15: Sorting, no band passes: composite fail
// R16: Clear erases results, restores idle lines
// R17: Auto-clear clears on new sequence start
// R18: Without auto-clear, controller issues clear
// R19: Wide port allows 16-bit patterns
// R20: Bit 0 drives line 1; 3-bit masks line 4
// R21: Fixed test order; first failure selects pattern
// R22: Last pattern held until update or clear
`ifndef LTBO_PARAMS_SVH
`define LTBO_PARAMS_SVH
`define LTBO_PAT_W 16
`define LTBO_NBANDS 11
`define LTBO_LOC_W 7
`define LTBO_LOC_MIN 7'h01
`define LTBO_LOC_MAX 7'h64
`define LTBO_MASK_3BIT 16'h0007
`define LTBO_MASK_4BIT 16'h000f
`define LTBO_MASK_16BIT 16'hffff
`define LTBO_ADDR_W 8
`define LTBO_A_CTRL 8'h00
`define LTBO_A_PASS_PAT 8'h04
`define LTBO_A_FAIL_PAT 8'h08
`define LTBO_A_IDLE_PAT 8'h0c
`define LTBO_A_COMP_PAT 8'h10
`define LTBO_A_PASS_LOC 8'h14
`define LTBO_A_FAIL_LOC 8'h18
`define LTBO_A_ENABLES 8'h1c
`define LTBO_A_STATUS 8'h20
`define LTBO_A_ACTION 8'h24
`define LTBO_A_BAND_LO 8'h40
`define LTBO_A_BAND_UP 8'h80
`define LTBO_CTRL_MODE 0
`define LTBO_CTRL_UPD 1
`define LTBO_CTRL_AUTO 2
`define LTBO_CTRL_WID_LO 3
`define LTBO_ACT_CLEAR 0
`define LTBO_ACT_END 1
`endif

// [ltbo_pkg.sv]
// Types for the limit test binning output block
package ltbo_pkg;
	typedef enum logic [1:0] {
		LTBO_W3 = 2'b00,
		LTBO_W4 = 2'b01,
		LTBO_W16 = 2'b10
	} ltbo_width_t;
	typedef enum logic {
		LTBO_GRADING = 1'b0,
		LTBO_SORTING = 1'b1
	} ltbo_mode_t;
	typedef enum logic {
		LTBO_IDLE = 1'b0,
		LTBO_HELD = 1'b1
	} ltbo_state_t;
endpackage : ltbo_pkg

// [ltbo_eval.sv]
// Combinational evaluation of one reading into a pass flag and pattern
`timescale 1ns/1ns
`include "ltbo_params.svh"
module ltbo_eval
	import ltbo_pkg::*;
(
	input wire ltbo_mode_t i_mode,
	input wire logic i_comp_en,
	input wire logic i_comp_fail,
	input wire logic [`LTBO_NBANDS-1:0] i_band_en,
	input wire logic [`LTBO_NBANDS-1:0] i_lo_fail,
	input wire logic [`LTBO_NBANDS-1:0] i_up_fail,
	input wire logic [`LTBO_NBANDS*`LTBO_PAT_W-1:0] i_lo_pat,
	input wire logic [`LTBO_NBANDS*`LTBO_PAT_W-1:0] i_up_pat,
	input wire logic [`LTBO_PAT_W-1:0] i_comp_pat,
	input wire logic [`LTBO_PAT_W-1:0] i_pass_pat,
	input wire logic [`LTBO_PAT_W-1:0] i_fail_pat,
	output logic o_pass,
	output logic [`LTBO_PAT_W-1:0] o_pattern
);
	// Band index 0 is band 2, then 3, then 5 to 13 ascending
	logic [`LTBO_NBANDS:0] g_found;
	logic [`LTBO_PAT_W-1:0] g_pat [`LTBO_NBANDS:0];
	logic [`LTBO_NBANDS:0] s_found;
	logic [`LTBO_PAT_W-1:0] s_pat [`LTBO_NBANDS:0];
	assign g_found[0] = 1'b0;
	assign g_pat[0] = '0;
	assign s_found[0] = 1'b0;
	assign s_pat[0] = '0;
	genvar b;
	generate
		for (b = 0; b < `LTBO_NBANDS; b++) begin : g_band
			logic lo_hit;
			logic up_hit;
			logic in_band;
			assign lo_hit = i_band_en[b] & i_lo_fail[b];
			assign up_hit = i_band_en[b] & i_up_fail[b];
			assign in_band = i_band_en[b] & ~i_lo_fail[b] & ~i_up_fail[b];
			// Lower before upper within a band, earlier band wins R21
			assign g_found[b+1] = g_found[b] | lo_hit | up_hit;
			assign g_pat[b+1] = g_found[b] ? g_pat[b] :
				lo_hit ? i_lo_pat[b*`LTBO_PAT_W +: `LTBO_PAT_W] :
				up_hit ? i_up_pat[b*`LTBO_PAT_W +: `LTBO_PAT_W] : g_pat[b];
			// First passing band gives its lower pattern R13
			assign s_found[b+1] = s_found[b] | in_band;
			assign s_pat[b+1] = s_found[b] ? s_pat[b] :
				in_band ? i_lo_pat[b*`LTBO_PAT_W +: `LTBO_PAT_W] : s_pat[b];
		end
	endgenerate
	logic comp_bad;
	assign comp_bad = i_comp_en & i_comp_fail;
	always_comb begin
		o_pass = 1'b1;
		o_pattern = i_pass_pat; // R1
		if (i_mode == LTBO_GRADING) begin
			if (comp_bad) begin // R9 R10
				o_pass = 1'b0;
				o_pattern = i_comp_pat;
			end else if (g_found[`LTBO_NBANDS]) begin // R10
				o_pass = 1'b0;
				o_pattern = g_pat[`LTBO_NBANDS];
			end
		end else begin
			if (comp_bad) begin // R14 R11
				o_pass = 1'b0;
				o_pattern = i_comp_pat;
			end else if (i_band_en == '0) begin // R3 R12
				o_pattern = i_pass_pat;
			end else if (s_found[`LTBO_NBANDS]) begin // R13
				o_pattern = s_pat[`LTBO_NBANDS];
			end else begin // R15 R2 R11
				o_pass = 1'b0;
				o_pattern = i_fail_pat;
			end
		end
	end
endmodule : ltbo_eval

// [ltbo_branch.sv]
// Next source-memory location from branch settings and the outcome
`timescale 1ns/1ns
`include "ltbo_params.svh"
module ltbo_branch (
	input wire logic [`LTBO_LOC_W-1:0] i_cur_loc,
	input wire logic [`LTBO_LOC_W-1:0] i_pass_loc,
	input wire logic [`LTBO_LOC_W-1:0] i_fail_loc,
	input wire logic i_pass,
	output logic [`LTBO_LOC_W-1:0] o_next_loc
);
	// Location 0 stands for the next-location setting
	logic pass_set;
	logic fail_set;
	assign pass_set = (i_pass_loc >= `LTBO_LOC_MIN) &&
		(i_pass_loc <= `LTBO_LOC_MAX);
	assign fail_set = (i_fail_loc >= `LTBO_LOC_MIN) &&
		(i_fail_loc <= `LTBO_LOC_MAX);
	always_comb begin
		o_next_loc = i_cur_loc + 7'h01; // R6
		if (i_pass && pass_set) begin // R4
			o_next_loc = i_pass_loc;
		end else if (!i_pass && fail_set) begin // R5
			o_next_loc = i_fail_loc;
		end
	end
endmodule : ltbo_branch

// [ltbo_handler.sv]
// Component handler model that bins a part from the output pattern lines
`timescale 1ns/1ns
`include "ltbo_params.svh"
module ltbo_handler #(
	parameter int SETTLE = 2
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [`LTBO_PAT_W-1:0] i_lines,
	input wire logic i_lines_valid,
	output logic [`LTBO_PAT_W-1:0] o_bin,
	output logic o_binned
);
	// ********
	// Binning
	// ********
	int wait_q;
	// A slow handler: lines must stand SETTLE cycles before it bins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_q <= 0;
			o_bin <= 16'h0000;
			o_binned <= 1'b0;
		end else if (i_lines_valid !== 1'b1) begin
			wait_q <= 0;
			o_binned <= 1'b0;
		end else if (wait_q < SETTLE) begin
			wait_q <= wait_q + 1;
		end else if (!o_binned) begin
			o_bin <= i_lines;
			o_binned <= 1'b1;
		end
	end
endmodule : ltbo_handler

// [testbench.sv]
// Self-checking bench for the limit test binning output block
`timescale 1ns/1ns
`include "ltbo_params.svh"
module testbench;
	import ltbo_pkg::*;
	// ********
	// Signals and instances
	// ********
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_seq_start = 1'b0;
	logic i_result_valid = 1'b0;
	logic i_comp_fail = 1'b0;
	logic i_sweep_done = 1'b0;
	logic [`LTBO_ADDR_W-1:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic [`LTBO_NBANDS-1:0] i_lo_fail = 11'h000;
	logic [`LTBO_NBANDS-1:0] i_up_fail = 11'h000;
	logic [`LTBO_LOC_W-1:0] i_cur_loc = 7'h0a;
	logic [31:0] o_rdata;
	logic [`LTBO_PAT_W-1:0] o_output_pattern;
	logic [`LTBO_PAT_W-1:0] bin_pat;
	logic [`LTBO_LOC_W-1:0] o_branch_location;
	logic o_pattern_valid;
	logic o_branch_valid;
	logic o_any_fail;
	logic bin_done;
	int bad_count = 0;
	int samples_checked = 0;
	// Rows: mode, enables, compliance, lower, upper, pattern, failed
	logic [51:0] rows [12] = '{52'h0fff000000050, 52'h0fff0002001f1,
		52'h0fff000100011, 52'h0fff17ff7ffc1, 52'h0005000100050,
		52'h00050000002e1, 52'h1007000100020, 52'h1007000000010,
		52'h10071000000c1, 52'h1007000300091, 52'h1001000000050,
		52'h1007000000120};
	// Rows: pass location, fail location, compliance, next location
	logic [31:0] brows [6] = '{32'h0000000b, 32'h0000010b, 32'h64000064,
		32'h6400010b, 32'h00010101, 32'h0001000b};

	initial begin
		forever #50 i_clk = ~i_clk;
	end

	ltbo_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_seq_start(i_seq_start), .i_result_valid(i_result_valid),
		.i_comp_fail(i_comp_fail), .i_lo_fail(i_lo_fail),
		.i_up_fail(i_up_fail), .i_cur_loc(i_cur_loc),
		.i_sweep_done(i_sweep_done), .o_output_pattern(o_output_pattern),
		.o_pattern_valid(o_pattern_valid),
		.o_branch_location(o_branch_location),
		.o_branch_valid(o_branch_valid), .o_any_fail(o_any_fail));

	ltbo_handler #(.SETTLE(2)) i_handler (.i_clk(i_clk), .i_rst(i_rst),
		.i_lines(o_output_pattern), .i_lines_valid(o_pattern_valid),
		.o_bin(bin_pat), .o_binned(bin_done));

	// ********
	// Shared tasks
	// ********
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd

	task automatic ctrl(input logic m, u, au, input logic [1:0] w);
		wr(`LTBO_A_CTRL, {27'h0, w, au, u, m});
	endtask : ctrl

	// Waits for the branch strobe, which comes whether or not the pattern updates
	task automatic result(input logic c, input logic [10:0] lo,
		input logic [10:0] up);
		int n;
		@(posedge i_clk);
		i_comp_fail <= c;
		i_lo_fail <= lo;
		i_up_fail <= up;
		i_result_valid <= 1'b1;
		@(posedge i_clk);
		i_result_valid <= 1'b0;
		#1;
		for (n = 0; n < 4 && o_branch_valid !== 1'b1; n++) begin
			@(posedge i_clk);
			#1;
		end
		if (n == 4) begin
			bad_count++;
			print_verdict();
		end
	endtask : result

	task automatic pulse(input logic sweep);
		@(posedge i_clk);
		if (sweep) begin
			i_sweep_done <= 1'b1;
		end else begin
			i_seq_start <= 1'b1;
		end
		@(posedge i_clk);
		i_sweep_done <= 1'b0;
		i_seq_start <= 1'b0;
		#1;
	endtask : pulse

	task automatic chk_out(input logic [15:0] p, input logic v, f);
		#1;
		check({14'h0, o_any_fail, o_pattern_valid, o_output_pattern},
			{14'h0, f, v, p});
	endtask : chk_out

	// ********
	// Scenarios
	// ********
	task automatic s_reset_setup();
		logic [31:0] d;
		int i;
		chk_out(16'h0000, 1'b0, 1'b0);
		rd(`LTBO_A_CTRL, d);
		check(d, 32'h00000008);
		rd(8'h30, d);
		check(d, 32'h00000000);
		wr(`LTBO_A_PASS_PAT, 32'h5);
		wr(`LTBO_A_FAIL_PAT, 32'h9);
		wr(`LTBO_A_IDLE_PAT, 32'h6);
		wr(`LTBO_A_COMP_PAT, 32'hc);
		for (i = 0; i < `LTBO_NBANDS; i++) begin
			wr(8'(`LTBO_A_BAND_LO + 4 * i), 32'(i + 1));
			wr(8'(`LTBO_A_BAND_UP + 4 * i), 32'(15 - i));
		end
		rd(`LTBO_A_PASS_PAT, d);
		check(d, 32'h00000005);
	endtask : s_reset_setup

	task automatic s_eval();
		logic [51:0] r;
		int i;
		for (i = 0; i < 12; i++) begin
			r = rows[i];
			ctrl(r[48], 1'b0, 1'b0, 2'h1);
			wr(`LTBO_A_ENABLES, {20'h0, r[47:36]});
			wr(`LTBO_A_ACTION, 32'h1);
			result(r[32], r[30:20], r[18:8]);
			chk_out(16'(r[7:4]), 1'b1, r[0]);
		end
	endtask : s_eval

	task automatic s_hold_clear();
		ctrl(1'b0, 1'b0, 1'b0, 2'h1);
		wr(`LTBO_A_ENABLES, 32'hfff);
		wr(`LTBO_A_ACTION, 32'h1);
		result(1'b0, 11'h000, 11'h000);
		chk_out(16'h0005, 1'b1, 1'b0);
		result(1'b0, 11'h002, 11'h000);
		chk_out(16'h0002, 1'b1, 1'b1);
		result(1'b1, 11'h000, 11'h000);
		chk_out(16'h0002, 1'b1, 1'b1);
		pulse(1'b0);
		chk_out(16'h0002, 1'b1, 1'b1);
		ctrl(1'b0, 1'b0, 1'b1, 2'h1);
		pulse(1'b0);
		chk_out(16'h0006, 1'b0, 1'b0);
		result(1'b1, 11'h000, 11'h000);
		wr(`LTBO_A_ACTION, 32'h1);
		chk_out(16'h0006, 1'b0, 1'b0);
		// Sequence start and a failing result in one cycle
		@(posedge i_clk);
		i_seq_start <= 1'b1;
		i_comp_fail <= 1'b1;
		i_result_valid <= 1'b1;
		@(posedge i_clk);
		i_seq_start <= 1'b0;
		i_result_valid <= 1'b0;
		chk_out(16'h000c, 1'b1, 1'b1);
	endtask : s_hold_clear

	task automatic s_end_mode();
		ctrl(1'b0, 1'b1, 1'b0, 2'h1);
		wr(`LTBO_A_ACTION, 32'h1);
		result(1'b0, 11'h001, 11'h000);
		result(1'b0, 11'h000, 11'h000);
		#1;
		check({15'h0, o_pattern_valid, o_output_pattern}, 32'h00006);
		pulse(1'b1);
		chk_out(16'h0001, 1'b1, 1'b1);
		repeat (5) @(posedge i_clk);
		#1;
		check({15'h0, bin_done, bin_pat}, 32'h00010001);
		wr(`LTBO_A_ACTION, 32'h1);
		result(1'b0, 11'h000, 11'h000);
		wr(`LTBO_A_ACTION, 32'h2);
		chk_out(16'h0005, 1'b1, 1'b0);
	endtask : s_end_mode

	task automatic s_width();
		ctrl(1'b0, 1'b0, 1'b0, 2'h0);
		wr(`LTBO_A_PASS_PAT, 32'hf);
		wr(`LTBO_A_ACTION, 32'h1);
		result(1'b0, 11'h000, 11'h000);
		chk_out(16'h0007, 1'b1, 1'b0);
		ctrl(1'b0, 1'b0, 1'b0, 2'h2);
		wr(`LTBO_A_PASS_PAT, 32'habcd);
		wr(`LTBO_A_ACTION, 32'h1);
		result(1'b0, 11'h000, 11'h000);
		chk_out(16'habcd, 1'b1, 1'b0);
	endtask : s_width

	task automatic s_branch();
		logic [31:0] b;
		int i;
		for (i = 0; i < 6; i++) begin
			b = brows[i];
			wr(`LTBO_A_PASS_LOC, {24'h0, b[31:24]});
			wr(`LTBO_A_FAIL_LOC, {24'h0, b[23:16]});
			result(b[8], 11'h000, 11'h000);
			check({25'h0, o_branch_location}, {25'h0, b[6:0]});
		end
	endtask : s_branch

	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		s_reset_setup();
		s_eval();
		s_hold_clear();
		s_end_mode();
		s_width();
		s_branch();
		print_verdict();
	end
endmodule : testbench
